// ### hw/eeprom_slave.sv
`timescale 1ns/1ns
`include "eeprom_map.svh"


module eeprom_slave #(
  parameter logic [3:0] DEVICE_TYPE = 4'h5, // Arbitrary type code
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter int FIFO_DEPTH = `PAGE_BYTES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic write_protect,
  input wire logic device_select_bit0,
  input wire logic device_select_bit1,
  input wire logic device_select_bit2,
  output logic busy,
  output logic standby
);
  import eeprom_pkg::*;

  localparam int TW = $clog2(PROG_CYCLES + 1);

  generate
    if (PROG_CYCLES < 1) begin : g_bad_prog
      $error("programming time must be at least one cycle");
    end
    if (FIFO_DEPTH < `PAGE_BYTES) begin : g_bad_fifo
      $error("write FIFO must hold a whole page");
    end
  endgenerate

  // ****************************************
  // Helpers
  // ****************************************
  // Page wrap: upper bits hold, offset rolls within the page
  function automatic logic [7:0] page_inc(input logic [7:0] a);
    page_inc = {a[7:`PAGE_OFS_W], (`PAGE_OFS_W)'(a[`PAGE_OFS_W-1:0] + 1'b1)};
  endfunction

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  pins_t raw_pins, pins;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign raw_pins = '{scl: scl_in, sda: sda_in, wp: write_protect,
                      sel: {device_select_bit2, device_select_bit1, device_select_bit0}};

  pin_sync #(.W($bits(pins_t))) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(raw_pins),
    .q(pins)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= pins.scl;
      sda_q <= pins.sda;
    end
  end

  assign scl_rise = pins.scl && !scl_q;
  assign scl_fall = !pins.scl && scl_q;
  // Any SDA change while SCL stays high is a bus condition
  assign start_cond = pins.scl && scl_q && sda_q && !pins.sda;
  assign stop_cond = pins.scl && scl_q && !sda_q && pins.sda;

  // ****************************************
  // Protocol state
  // ****************************************
  proto_state_t state, after_ack;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [7:0] tx, ptr, rx_byte, rd_byte;
  logic [7:`PAGE_OFS_W] page;
  logic ack_on, sda_low, wrote, rx_valid, rx_ready;
  page_entry_t rx_entry;
  logic byte_end, type_ok, sel_ok, dev_hit, commit_now;
  logic [7:0] mem [`ARRAY_BYTES];

  assign rx_byte = {shift, pins.sda};
  assign byte_end = scl_rise && (bit_cnt == 3'h7);
  assign type_ok = (rx_byte[`TYPE_MSB:`TYPE_LSB] == DEVICE_TYPE);
  assign sel_ok = (rx_byte[`SEL_MSB:`SEL_LSB] == pins.sel);
  // Busy parts stay deaf, which is what lets the master poll
  assign dev_hit = type_ok && sel_ok && !busy;
  assign rd_byte = mem[ptr];
  assign sda_out = 1'b0;
  assign sda_oe_n = !sda_low;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      page <= '0;
      ack_on <= 1'b0;
      sda_low <= 1'b0;
      wrote <= 1'b0;
      rx_valid <= 1'b0;
      rx_entry <= '0;
    end else begin
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end
      if (start_cond) begin
        // Start aborts anything half done, including a stuck read
        state <= ST_DEV;
        bit_cnt <= 3'h0;
        ack_on <= 1'b0;
        sda_low <= 1'b0;
        wrote <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        ack_on <= 1'b0;
        sda_low <= 1'b0;
        wrote <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
          end
          ST_DEV, ST_WADDR, ST_WDATA: begin
            if (scl_rise) begin
              shift <= rx_byte[6:0];
              bit_cnt <= 3'(bit_cnt + 1'b1);
            end
            if (byte_end && state == ST_DEV) begin
              if (dev_hit) begin
                state <= ST_ACK_OUT;
                after_ack <= rx_byte[`DIR_BIT] ? ST_READ : ST_WADDR;
                tx <= rd_byte;
              end else begin
                state <= ST_IDLE;
              end
            end
            if (byte_end && state == ST_WADDR) begin
              ptr <= rx_byte;
              page <= rx_byte[7:`PAGE_OFS_W];
              state <= ST_ACK_OUT;
              after_ack <= ST_WDATA;
            end
            if (byte_end && state == ST_WDATA) begin
              rx_entry <= '{offset: ptr[`PAGE_OFS_W-1:0], data: rx_byte};
              rx_valid <= 1'b1;
              ptr <= page_inc(ptr);
              wrote <= 1'b1;
              state <= ST_ACK_OUT;
              after_ack <= ST_WDATA;
            end
          end
          ST_ACK_OUT: begin
            if (scl_fall && !ack_on) begin
              ack_on <= 1'b1;
              sda_low <= 1'b1;
            end else if (scl_fall) begin
              ack_on <= 1'b0;
              bit_cnt <= 3'h0;
              state <= after_ack;
              sda_low <= (after_ack == ST_READ) ? !tx[7] : 1'b0;
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              sda_low <= !tx[7];
            end
            if (scl_rise) begin
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= 3'(bit_cnt + 1'b1);
            end
            if (byte_end) begin
              state <= ST_ACK_IN;
              ptr <= 8'(ptr + 8'h01);
            end
          end
          ST_ACK_IN: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
            end
            if (scl_rise && !pins.sda) begin
              tx <= rd_byte;
              bit_cnt <= 3'h0;
              state <= ST_READ;
            end else if (scl_rise) begin
              state <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Write path: FIFO into the page latch
  // ****************************************
  page_entry_t fifo_out;
  logic fifo_valid, fifo_ready, discard;
  logic [7:0] latch [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] mask;

  // Latch stalls the FIFO on the cycle it is being copied out
  assign fifo_ready = !commit_now;
  assign discard = stop_cond && wrote && pins.wp;

  byte_fifo #(.WIDTH($bits(page_entry_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_entry),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge core_clk) begin
    if (fifo_valid && fifo_ready) begin
      latch[fifo_out.offset] <= fifo_out.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask <= '0;
    end else if (commit_now || discard || (start_cond && !busy)) begin
      mask <= '0;
    end else if (fifo_valid && fifo_ready) begin
      mask[fifo_out.offset] <= 1'b1;
    end
  end

  // ****************************************
  // Self-timed programming
  // ****************************************
  logic [TW-1:0] timer;

  assign commit_now = busy && (timer == TW'(PROG_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
      timer <= '0;
    end else if (busy) begin
      busy <= !commit_now;
      timer <= TW'(timer + 1'b1);
    end else if (stop_cond && wrote && !pins.wp) begin
      busy <= 1'b1;
      timer <= '0;
    end
  end

  // Array keeps no reset: its contents are the stored data
  always_ff @(posedge core_clk) begin
    if (commit_now) begin
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        if (mask[i]) begin
          mem[{page, (`PAGE_OFS_W)'(i)}] <= latch[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      standby <= 1'b1;
    end else begin
      standby <= (state == ST_IDLE) && !busy && !wrote && !stop_cond;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_start_resets;
    start_cond |=> (state == ST_DEV) && (bit_cnt == 3'h0) && sda_oe_n;
  endproperty
  a_start_resets: assert property (p_start_resets) else $error("start did not restart protocol");
  property p_stop_idles;
    stop_cond |=> (state == ST_IDLE) && sda_oe_n;
  endproperty
  a_stop_idles: assert property (p_stop_idles) else $error("stop did not return to idle");
  property p_type_mismatch;
    (state == ST_DEV) && byte_end && !type_ok |=> (state == ST_IDLE) ##1 sda_oe_n;
  endproperty
  a_type_mismatch: assert property (p_type_mismatch) else $error("wrong type code answered");
  property p_sel_mismatch;
    (state == ST_DEV) && byte_end && !sel_ok |=> state == ST_IDLE;
  endproperty
  a_sel_mismatch: assert property (p_sel_mismatch) else $error("wrong select straps answered");
  property p_dir_read;
    (state == ST_DEV) && byte_end && dev_hit && pins.sda |=> (after_ack == ST_READ) && (state == ST_ACK_OUT);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("read bit did not select read");
  property p_ack_drive;
    (state == ST_ACK_OUT) && scl_fall && !ack_on && !start_cond && !stop_cond |=> !sda_oe_n;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");
  property p_busy_silent;
    busy |-> sda_oe_n && (state != ST_ACK_OUT);
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("bus answered while programming");
  property p_page_wrap;
    (state == ST_WDATA) && byte_end && !start_cond && !stop_cond |=> ptr == page_inc($past(ptr));
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("write pointer left its page");
  property p_read_inc;
    (state == ST_READ) && byte_end && !start_cond && !stop_cond |=> ptr == 8'($past(ptr) + 8'h01);
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read pointer did not advance");
  property p_commit_clears;
    $fell(busy) |-> (mask == '0) && !fifo_valid;
  endproperty
  a_commit_clears: assert property (p_commit_clears) else $error("page latch not consumed by programming");
  property p_wp_skip;
    stop_cond && wrote && pins.wp |=> !busy [*2];
  endproperty
  a_wp_skip: assert property (p_wp_skip) else $error("protected write started programming");

endmodule // eeprom_slave

// ### hw/eeprom_map.svh
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ****************************************
// Array and page geometry
// ****************************************
`define ARRAY_BYTES 32'h0000_0100
`define PAGE_BYTES 32'h0000_0010
`define ADDR_W 32'h0000_0008
`define PAGE_OFS_W 32'h0000_0004

// ****************************************
// Address byte field positions
// ****************************************
`define TYPE_MSB 32'h0000_0007
`define TYPE_LSB 32'h0000_0004
`define SEL_MSB 32'h0000_0003
`define SEL_LSB 32'h0000_0001
`define DIR_BIT 32'h0000_0000

// ****************************************
// Timing: 5 ms programming at a 50 ns clock
// ****************************************
`define PROG_TIME_NS 32'h004C_4B40
`define CLK_PERIOD_NS 32'h0000_0032
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### hw/eeprom_pkg.sv
`include "eeprom_map.svh"

package eeprom_pkg;

  // ****************************************
  // Protocol states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_ACK_OUT,
    ST_READ,
    ST_ACK_IN
  } proto_state_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] sel;
  } pins_t;

  typedef struct packed {
    logic [`PAGE_OFS_W-1:0] offset;
    logic [7:0] data;
  } page_entry_t;

endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ns

module pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  generate
    if (W < 1) begin : g_bad_width
      $error("pin_sync needs at least one bit");
    end
  endgenerate

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pin_sync

// ### hw/byte_fifo.sv
`timescale 1ns/1ns

module byte_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("byte_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[rd_idx];

  always_ff @(posedge core_clk) begin
    if (push) begin
      store[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      wr_idx <= push ? AW'(wr_idx + 1'b1) : wr_idx;
      rd_idx <= pop ? AW'(rd_idx + 1'b1) : rd_idx;
      count <= (AW + 1)'(count + (AW + 1)'(push) - (AW + 1)'(pop));
    end
  end
endmodule // byte_fifo

// ### bench/bus_master.sv
`timescale 1ns/1ns

// ****************************************
// Two-wire bus master seen from the slave
// ****************************************
module bus_master (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic pull
);
  int stretch = 0;

  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Low phase is five cycles plus stretch so the slave's late release lands before the rise
  task automatic put_bit(input logic v, output logic seen);
    tick(2);
    pull <= ~v;
    tick(3 + stretch);
    scl <= 1'b1;
    tick(2);
    #5 seen = sda_line;
    tick(1);
    scl <= 1'b0;
  endtask

  task automatic start_cond;
    tick(2);
    pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic stop_cond;
    tick(2);
    pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    pull <= 1'b0;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    acked = ~s;
  endtask

  // Last byte of a read is left unacknowledged so the slave lets go of the line
  task automatic recv_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(~give_ack, s);
  endtask
endmodule // bus_master

// ### bench/tb_eeprom_slave.sv
`timescale 1ns/1ns

module tb_eeprom_slave;
  import eeprom_pkg::*;

  // ****************************************
  // Bench setup
  // ****************************************
  localparam logic [3:0] DEV_TYPE = 4'h9; // Arbitrary type code
  localparam logic [2:0] STRAPS = 3'h5;
  localparam int PROG = 200; // Short to wait out, still long enough to poll into
  localparam logic [3:0][7:0] MASKS = {8'h08, 8'h02, 8'h10, 8'h80};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic write_protect = 1'b0;
  logic sda_out;
  logic sda_oe_n;
  logic busy;
  logic standby;
  logic scl;
  logic pull;
  logic sda_line;
  logic [7:0] mem [256];
  int mismatches = 0;
  int check_count = 0;

  always #25 core_clk = ~core_clk;
  // Pull-up: the line is low while either side pulls it
  assign sda_line = ~pull & (sda_oe_n | sda_out);

  eeprom_slave #(.DEVICE_TYPE(DEV_TYPE), .PROG_CYCLES(PROG)) u_eeprom_slave (
    .core_clk(core_clk),
    .rst(rst),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .write_protect(write_protect),
    .device_select_bit0(STRAPS[0]),
    .device_select_bit1(STRAPS[1]),
    .device_select_bit2(STRAPS[2]),
    .busy(busy),
    .standby(standby)
  );

  bus_master u_bus_master (
    .core_clk(core_clk),
    .sda_line(sda_line),
    .scl(scl),
    .pull(pull)
  );

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] dev_addr(input logic rd);
    return {DEV_TYPE, STRAPS, rd};
  endfunction

  task automatic put(input logic [7:0] b);
    logic acked;
    u_bus_master.send_byte(b, acked);
    check("byte acknowledge", 8'h01, {7'h00, acked});
  endtask

  task automatic wait_idle;
    int n;
    repeat (4) @(posedge core_clk);
    #1;
    for (n = 0; n < PROG + 50 && busy !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (busy !== 1'b0) begin
      mismatches++;
      $display("ERROR busy expected 0 seen %b", busy);
      results();
    end
  endtask

  // Offset wraps inside the page; protected writes leave the expected image alone
  task automatic write_bytes(input logic [7:0] word, input int n, input logic [7:0] base);
    u_bus_master.start_cond();
    put(dev_addr(1'b0));
    put(word);
    for (int i = 0; i < n; i++) begin
      put(base + 8'(i));
      if (write_protect !== 1'b1) mem[{word[7:4], 4'(word[3:0] + i)}] = base + 8'(i);
    end
    u_bus_master.stop_cond();
  endtask

  task automatic read_bytes(input logic [7:0] first, input int n);
    logic [7:0] b;
    u_bus_master.start_cond();
    put(dev_addr(1'b1));
    for (int i = 0; i < n; i++) begin
      u_bus_master.recv_byte(i != n - 1, b);
      check("read data", mem[first + 8'(i)], b);
    end
    u_bus_master.stop_cond();
  endtask

  task automatic set_ptr(input logic [7:0] word);
    u_bus_master.start_cond();
    put(dev_addr(1'b0));
    put(word);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check("sda_oe_n", 8'h01, {7'h00, sda_oe_n});
    check("busy", 8'h00, {7'h00, busy});
    check("standby", 8'h01, {7'h00, standby});
    $display("test reset done");
  endtask

  task automatic t_refused;
    logic acked;
    for (int i = 0; i < 4; i++) begin
      u_bus_master.start_cond();
      u_bus_master.send_byte(dev_addr(1'b0) ^ MASKS[i], acked);
      check("foreign address acknowledge", 8'h00, {7'h00, acked});
      u_bus_master.stop_cond();
    end
    $display("test refused addresses done");
  endtask

  task automatic t_page_write;
    logic acked;
    write_bytes(8'h2E, 18, 8'h30);
    @(posedge core_clk);
    #1;
    check("busy after stop", 8'h01, {7'h00, busy});
    check("standby while busy", 8'h00, {7'h00, standby});
    u_bus_master.start_cond();
    u_bus_master.send_byte(dev_addr(1'b0), acked);
    check("poll while busy", 8'h00, {7'h00, acked});
    u_bus_master.stop_cond();
    wait_idle();
    // Standby is registered, so it follows busy by one clock
    @(posedge core_clk);
    #1;
    check("standby after programming", 8'h01, {7'h00, standby});
    set_ptr(8'h20);
    read_bytes(8'h20, 16);
    $display("test page write done");
  endtask

  task automatic t_wrap_read;
    u_bus_master.stretch = 3;
    write_bytes(8'hFF, 1, 8'h5C);
    wait_idle();
    write_bytes(8'h00, 2, 8'hC3);
    wait_idle();
    set_ptr(8'hFF);
    read_bytes(8'hFF, 2);
    read_bytes(8'h01, 1);
    @(posedge core_clk);
    #1;
    check("standby after read", 8'h01, {7'h00, standby});
    u_bus_master.stretch = 0;
    $display("test wrapping read done");
  endtask

  task automatic t_protect;
    write_protect <= 1'b1;
    repeat (4) @(posedge core_clk);
    write_bytes(8'h20, 1, ~mem[8'h20]);
    repeat (8) @(posedge core_clk);
    #1;
    check("busy under protect", 8'h00, {7'h00, busy});
    @(posedge core_clk);
    write_protect <= 1'b0;
    set_ptr(8'h20);
    read_bytes(8'h20, 1);
    $display("test write protect done");
  endtask

  task automatic t_recovery;
    logic s;
    u_bus_master.start_cond();
    put(dev_addr(1'b0));
    for (int i = 0; i < 3; i++) u_bus_master.put_bit(1'b0, s);
    read_bytes(8'h21, 1);
    $display("test recovery done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    t_reset();
    t_refused();
    t_page_write();
    t_wrap_read();
    t_protect();
    t_recovery();
    results();
  end
endmodule // tb_eeprom_slave
